// ==== bench/serial_host.sv ====
// Host controller model for the three-wire serial programming port.
// Assumes the bank shifts data on rising serial clock while strobe low.
`timescale 1ns/1ps
module serial_host (
  // Serial programming port.
  output logic serialClk,
  output logic serialData,
  output logic latchStrobe
);
  // Idle port: clock still, strobe high, data line released.
  initial begin
    serialClk = 1'b0;
    serialData = 1'b0;
    latchStrobe = 1'b1;
  end

  // shift then load
  // The clock only runs inside a frame, so no serial edge ever lands
  // while the strobe is high and the bank is taking the word.
  task automatic send(input logic [21:0] w, input logic rise);
    latchStrobe = 1'b0;
    #10;
    for (int i = 21; i >= 0; i--) begin
      serialData = w[i];
      #7.5 serialClk = 1'b1;
      #7.5 serialClk = 1'b0;
    end
    // Released line no longer shows the last bit.
    serialData = ~serialData;
    #7.5;
    if (rise) begin
      latchStrobe = 1'b1;
      #60;
    end
  endtask
endmodule

// ==== bench/synth_config_registers_asserts.sv ====
// Checker for the synthesizer register bank, bound to its top module.
// Assumes only the top module's ports, all seen in the clk_sys domain.
`timescale 1ns/1ps
module synth_config_registers_asserts (
  // Clock, reset and bus handshake.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Serial framing.
  input wire logic latchStrobe,
  // Decoded fields.
  input wire logic [1:0] rfPumpCurrent,
  input wire logic [8:0] rfPumpCurrentUa,
  input wire logic rfPrescalerSelect,
  input wire logic [4:0] rfPrescalerModulus,
  input wire logic [2:0] rfRefDivider,
  input wire logic [12:0] rfModuloExtension,
  input wire logic rfModulusExtended,
  input wire logic rfEnable,
  input wire logic ifEnable,
  input wire logic powerDown,
  input wire logic [16:0] ifMainDivider,
  input wire logic [7:0] rfFractionWord,
  input wire logic [11:0] rfMainDivider,
  input wire logic fracModeValid,
  input wire logic ditherEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_pumpUa;
    rfPumpCurrentUa == 9'h078 * ({7'h00, rfPumpCurrent} + 9'h001);
  endproperty
  a_pumpUa: assert property (p_pumpUa)
    else $error("pump current does not follow its code");
  property p_presc;
    rfPrescalerModulus == (rfPrescalerSelect ? 5'h10 : 5'h08);
  endproperty
  a_presc: assert property (p_presc)
    else $error("prescaler modulus does not follow select");
  property p_modExt;
    rfModulusExtended == (rfModuloExtension != 13'h0000);
  endproperty
  a_modExt: assert property (p_modExt)
    else $error("extension flag disagrees with field");
  property p_pdOff;
    powerDown |-> !rfEnable && !ifEnable;
  endproperty
  a_pdOff: assert property (p_pdOff)
    else $error("synthesizer enabled in power-down");
  property p_oneOn;
    !powerDown |-> rfEnable || ifEnable;
  endproperty
  a_oneOn: assert property (p_oneOn)
    else $error("nothing enabled outside power-down");
  property p_narrow;
    !rfPrescalerSelect |-> !rfMainDivider[11];
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("top divider bit used with small prescaler");
  property p_dither;
    ditherEnable |-> fracModeValid;
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither set outside a fractional mode");
  property p_hold;
    !latchStrobe [*6] |-> $stable(ifMainDivider) && $stable(rfMainDivider)
      && $stable(rfFractionWord) && $stable(rfRefDivider);
  endproperty
  a_hold: assert property (p_hold)
    else $error("field changed while strobe low");
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not after one wait cycle");
endmodule

bind synth_config_registers synth_config_registers_asserts u_chk (
  .clk_sys, .rst_n, .read, .write, .waitrequest, .latchStrobe,
  .rfPumpCurrent, .rfPumpCurrentUa, .rfPrescalerSelect,
  .rfPrescalerModulus, .rfRefDivider, .rfModuloExtension,
  .rfModulusExtended, .rfEnable, .ifEnable, .powerDown, .ifMainDivider,
  .rfFractionWord, .rfMainDivider, .fracModeValid, .ditherEnable
);

// ==== bench/tb.sv ====
// Self-checking bench for the synthesizer register bank.
// Assumes the serial host model and the bound checker beside it.
`timescale 1ns/1ps
module tb
  import synth_cfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [6:0] address = 7'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, serialClk, serialData, latchStrobe;
  logic [1:0] rfPumpCurrent;
  logic [8:0] rfPumpCurrentUa;
  logic [4:0] rfPrescalerModulus;
  logic [2:0] rfRefDivider;
  logic [12:0] rfModuloExtension;
  logic [16:0] ifMainDivider;
  logic [7:0] rfFractionWord;
  logic [11:0] rfMainDivider;
  logic rfPrescalerSelect, rfModulusExtended, ifPdPolarity, rfEnable;
  logic ifEnable, powerDown, fracModeValid, ditherEnable;
  int numErrors = 0;
  int nTests = 0;
  logic [21:0] lastIf;

  synth_config_registers u_dut (.clk_sys, .rst_n, .address, .read,
    .write, .writedata, .readdata, .waitrequest, .serialClk, .serialData,
    .latchStrobe, .rfPumpCurrent, .rfPumpCurrentUa, .rfPrescalerSelect,
    .rfPrescalerModulus, .rfRefDivider, .rfModuloExtension,
    .rfModulusExtended, .ifPdPolarity, .rfEnable, .ifEnable, .powerDown,
    .ifMainDivider, .rfFractionWord, .rfMainDivider, .fracModeValid,
    .ditherEnable);
  serial_host u_host (.serialClk, .serialData, .latchStrobe);

  // Register clock, 100 MHz.
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The request stands until waitrequest is seen low at a rising edge;
  // read data is taken at that same edge. Only the watchdog ends a hang.
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic settle;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic t_frac;
    for (int m = 0; m < 4; m++) begin
      u_host.send({2'(m), 18'h0, ADDR_FRAC}, 1'b1);
      settle();
      chk("fracModeValid", 32'(m >= 2), 32'(fracModeValid));
      chk("ditherEnable", 32'(m == 2), 32'(ditherEnable));
    end
  endtask

  task automatic t_loop;
    logic [12:0] ext;
    for (int c = 0; c < 4; c++) begin
      ext = {13{c[0]}};
      u_host.send({ext, 3'(7 - c), c[1], 2'(c), 1'b0, ADDR_LOOP}, 1'b1);
      settle();
      chk("pumpUa", 32'(32'h78 * (c + 1)), 32'(rfPumpCurrentUa));
      chk("pumpCode", 32'(c), 32'(rfPumpCurrent));
      chk("presc", c[1] ? 32'h10 : 32'h08, 32'(rfPrescalerModulus));
      chk("prescSel", 32'(c[1]), 32'(rfPrescalerSelect));
      chk("refDivider", 32'(7 - c), 32'(rfRefDivider));
      chk("extOn", 32'(c[0]), 32'(rfModulusExtended));
      chk("moduloExt", 32'(ext), 32'(rfModuloExtension));
    end
  endtask

  task automatic t_ifctl;
    logic [2:0] en [4] = '{3'h6, 3'h4, 3'h2, 3'h1};
    for (int e = 0; e < 4; e++) begin
      lastIf = {17'(17'h1ffff >> e), 2'(e), e[0], ADDR_IFCTL};
      u_host.send(lastIf, 1'b1);
      settle();
      chk("ifPolarity", 32'(e[0]), 32'(ifPdPolarity));
      chk("enables", 32'(en[e]), 32'({rfEnable, ifEnable, powerDown}));
      chk("ifDivider", 32'(lastIf[21:5]), 32'(ifMainDivider));
    end
  endtask

  task automatic t_rfdiv;
    for (int p = 0; p < 2; p++) begin
      u_host.send({16'h0, p[0], 3'h0, ADDR_LOOP}, 1'b1);
      u_host.send({12'hfff, 8'(8'hfe + p), ADDR_RFDIV}, 1'b1);
      settle();
      chk("fraction", 32'(8'(8'hfe + p)), 32'(rfFractionWord));
      chk("rfDivider", p ? 32'hfff : 32'h7ff, 32'(rfMainDivider));
      chk("ifKept", 32'(lastIf[21:5]), 32'(ifMainDivider));
    end
  endtask

  // A frame without a strobe rise must change nothing.
  task automatic t_abort;
    u_host.send({17'h00123, 2'h1, 1'b1, ADDR_IFCTL}, 1'b0);
    settle();
    chk("noRise", 32'(lastIf[21:5]), 32'(ifMainDivider));
    lastIf = {17'h0abcd, 2'h0, 1'b0, ADDR_IFCTL};
    u_host.send(lastIf, 1'b1);
    settle();
    chk("afterRise", 32'(lastIf[21:5]), 32'(ifMainDivider));
  endtask

  task automatic t_bus;
    logic [31:0] q;
    bus(1'b0, OFS_IFCTL, 32'h0, q);
    chk("readIfWord", {10'h0, lastIf}, q);
    bus(1'b1, OFS_IFCTL, 32'h0, q);
    bus(1'b0, OFS_IFCTL, 32'h0, q);
    chk("wordReadOnly", {10'h0, lastIf}, q);
    bus(1'b0, 7'h1c, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask

  // Status flags, the accept switch and the injected word path.
  task automatic t_ctrl;
    logic [31:0] q;
    logic [21:0] inj;
    inj = {17'h1a5a5, 2'h1, 1'b1, ADDR_IFCTL};
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("status", 32'h0000003f, q);
    bus(1'b1, OFS_STATUS, 32'h0000000f, q);
    bus(1'b1, OFS_CTRL, 32'h0, q);
    u_host.send({17'h00777, 2'h2, 1'b0, ADDR_IFCTL}, 1'b1);
    settle();
    chk("shutOut", 32'(lastIf[21:5]), 32'(ifMainDivider));
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("statusClear", 32'h00000030, q);
    bus(1'b1, OFS_INJECT, 32'(inj), q);
    settle();
    chk("injected", 32'(inj[21:5]), 32'(ifMainDivider));
    chk("injEnable", 32'h4, 32'({rfEnable, ifEnable, powerDown}));
    bus(1'b1, OFS_CTRL, 32'h1, q);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("statusLoad", 32'h00000034, q);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence after a five-cycle reset.
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("rstPowerDown", 32'h1, 32'(powerDown));
    chk("rstMode", 32'h0, 32'(fracModeValid));
    chk("rstWait", 32'h1, 32'(waitrequest));
    t_frac();
    t_loop();
    t_ifctl();
    t_rfdiv();
    t_abort();
    t_bus();
    t_ctrl();
    results();
  end

  // Watchdog: the sequence needs about 10 us.
  initial begin
    #200000;
    numErrors++;
    results();
  end
endmodule

// ==== core/sync_stage.sv ====
// Two-flop level synchroniser into the register clock domain.
// Assumes the input is a level that stays put for several clocks.
`timescale 1ns/1ps
module sync_stage
  import synth_cfg_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Level in and synchronised level out.
  input wire logic [W-1:0] levelIn,
  output logic [W-1:0] levelOut
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = levelIn;
    st_nxt.stable = st_r.meta;
  end

  // Both stages reset to the idle level of the input.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign levelOut = st_r.stable;

endmodule

// ==== core/synth_cfg_pkg.sv ====
// Constants shared by the synthesizer configuration register bank.
// Assumes a three-wire serial port (serial clock, data, latch strobe)
// and an Avalon-MM register slave with 32-bit data.
// What this block does
// - Loop word bits 4:3 pick pump current.
// - Loop word bit 5 picks 8/9 or 16/17.
// - Loop word bits 8:6 are reference ratio.
// - Loop word bits 21:9 extend fractional modulus.
// - IF word bit 2 sets IF polarity.
// - IF word bits 4:3 set enables, power-down.
// - IF word bits 21:5 are IF main ratio.
// - Divider word bits 9:2 are fraction numerator.
// - Divider word 21:10 main ratio, 11/12 bits.
// - Word 00b bits 21:20 choose dithered fractional mode.
package synth_cfg_pkg;

  // Serial word layout.
  localparam int WORD_W = 22;
  localparam logic [1:0] ADDR_FRAC = 2'h0;
  localparam logic [1:0] ADDR_LOOP = 2'h1;
  localparam logic [1:0] ADDR_IFCTL = 2'h2;
  localparam logic [1:0] ADDR_RFDIV = 2'h3;

  // Field positions, loop setup word.
  localparam int PUMP_LSB = 3;
  localparam int PUMP_MSB = 4;
  localparam int PRESC_BIT = 5;
  localparam int REFDIV_LSB = 6;
  localparam int REFDIV_MSB = 8;
  localparam int MODEXT_LSB = 9;
  localparam int MODEXT_MSB = 21;
  // Field positions, IF control word.
  localparam int IFPOL_BIT = 2;
  localparam int EN_LSB = 3;
  localparam int EN_MSB = 4;
  localparam int IFDIV_LSB = 5;
  localparam int IFDIV_MSB = 21;
  // Field positions, RF divider word.
  localparam int FRAC_LSB = 2;
  localparam int FRAC_MSB = 9;
  localparam int RFDIV_LSB = 10;
  localparam int RFDIV_MSB = 21;
  localparam int RFDIV_NARROW_W = 11;
  // Field positions, word 00b.
  localparam int FMODE_LSB = 20;
  localparam int FMODE_MSB = 21;

  // Pump current in microamps per code.
  localparam logic [8:0] PUMP_UA_0 = 9'h078;
  localparam logic [8:0] PUMP_UA_1 = 9'h0f0;
  localparam logic [8:0] PUMP_UA_2 = 9'h168;
  localparam logic [8:0] PUMP_UA_3 = 9'h1e0;
  // Prescaler moduli.
  localparam logic [4:0] PRESC_MOD_SMALL = 5'h08;
  localparam logic [4:0] PRESC_MOD_LARGE = 5'h10;
  // Enable codes.
  localparam logic [1:0] EN_BOTH = 2'h0;
  localparam logic [1:0] EN_RF_ONLY = 2'h1;
  localparam logic [1:0] EN_IF_ONLY = 2'h2;
  localparam logic [1:0] EN_POWER_DOWN = 2'h3;
  // Fractional mode codes.
  localparam logic [1:0] FMODE_DITHER = 2'h2;
  localparam logic [1:0] FMODE_PLAIN = 2'h3;

  // Register indices; byte address is four times the index.
  localparam logic [4:0] IDX_FRAC = 5'h00;
  localparam logic [4:0] IDX_LOOP = 5'h01;
  localparam logic [4:0] IDX_IFCTL = 5'h02;
  localparam logic [4:0] IDX_RFDIV = 5'h03;
  localparam logic [4:0] IDX_CTRL = 5'h04;
  localparam logic [4:0] IDX_STATUS = 5'h05;
  localparam logic [4:0] IDX_INJECT = 5'h06;
  localparam logic [6:0] OFS_FRAC = {IDX_FRAC, 2'h0};
  localparam logic [6:0] OFS_LOOP = {IDX_LOOP, 2'h0};
  localparam logic [6:0] OFS_IFCTL = {IDX_IFCTL, 2'h0};
  localparam logic [6:0] OFS_RFDIV = {IDX_RFDIV, 2'h0};
  localparam logic [6:0] OFS_CTRL = {IDX_CTRL, 2'h0};
  localparam logic [6:0] OFS_STATUS = {IDX_STATUS, 2'h0};
  localparam logic [6:0] OFS_INJECT = {IDX_INJECT, 2'h0};

  // Control and status bits.
  localparam int CTRL_ACCEPT_BIT = 0;
  localparam int STAT_FMODE_SET_BIT = 4;
  localparam int STAT_FMODE_OK_BIT = 5;

  // Reset values.
  localparam logic [21:0] RST_FRAC_WORD = 22'h000000;
  localparam logic [21:0] RST_LOOP_WORD = 22'h000001;
  localparam logic [21:0] RST_IFCTL_WORD = 22'h000018;
  localparam logic [21:0] RST_RFDIV_WORD = 22'h000003;
  localparam logic RST_ACCEPT = 1'b1;
  localparam logic RST_STROBE = 1'b1;

endpackage

// ==== core/synth_config_registers.sv ====
// Configuration register bank of a dual RF/IF synthesizer.
// Words arrive on a three-wire serial port clocked by the host; the
// stored words are decoded into fields and are visible over Avalon-MM.
// Assumes the host keeps the serial clock still while the strobe is
// high, so the shifted word is quiet when the register side takes it.
// Software reads the stored words back over the bus; writes to them
// are ignored, so only serial loads and injected words change the fields.
// A word can also be injected over the bus for bring-up, and the
// serial port can be shut out through the control register.
`timescale 1ns/1ps
module synth_config_registers
  import synth_cfg_pkg::*;
(
  // Register clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [6:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial programming port.
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic latchStrobe,
  // Decoded RF loop setup.
  output logic [1:0] rfPumpCurrent,
  output logic [8:0] rfPumpCurrentUa,
  output logic rfPrescalerSelect,
  output logic [4:0] rfPrescalerModulus,
  output logic [2:0] rfRefDivider,
  output logic [12:0] rfModuloExtension,
  output logic rfModulusExtended,
  // Decoded IF control.
  output logic ifPdPolarity,
  output logic rfEnable,
  output logic ifEnable,
  output logic powerDown,
  output logic [16:0] ifMainDivider,
  // Decoded RF divider and fraction.
  output logic [7:0] rfFractionWord,
  output logic [11:0] rfMainDivider,
  // Decoded fractional mode.
  output logic fracModeValid,
  output logic ditherEnable
);

  // State of the serial-clock side.
  typedef struct packed {
    logic [WORD_W-1:0] shiftWord;
  } link_state_t;

  // State of the register-clock side.
  typedef struct packed {
    // Stored serial words.
    logic [WORD_W-1:0] fracWord;
    logic [WORD_W-1:0] loopWord;
    logic [WORD_W-1:0] ifCtlWord;
    logic [WORD_W-1:0] rfDivWord;
    // Crossing, control and status.
    logic strobeSeen;
    logic latchAccept;
    logic [3:0] updated;
    logic fracModeSet;
    // Bus handshake and read data.
    logic waitReq;
    logic [31:0] rdata;
    // Decoded RF loop setup.
    logic [1:0] pump;
    logic [8:0] pumpUa;
    logic presc;
    logic [4:0] prescMod;
    logic [2:0] refDiv;
    logic [12:0] modExt;
    logic modExtOn;
    // Decoded IF control.
    logic ifPol;
    logic rfEn;
    logic ifEn;
    logic pwrDown;
    logic [16:0] ifDiv;
    // Decoded divider, fraction and mode.
    logic [7:0] fracNum;
    logic [11:0] rfDiv;
    logic fmodeOk;
    logic dither;
  } sys_state_t;

  link_state_t link_r;
  link_state_t link_nxt;
  sys_state_t st_r;
  sys_state_t st_nxt;

  // Helpers of the register-side process and its read mux.
  logic strobeSync;
  logic strobeRise;
  logic busReq;
  logic busDone;
  logic doWrite;
  logic loadValid;
  logic [WORD_W-1:0] loadWord;
  logic [3:0] updHit;
  logic [1:0] enCode;
  logic [1:0] fmode;
  logic [31:0] rdMux;

  // serial shift path
  // Bits enter LSB last, so the address lands in bits 1:0. The strobe is
  // sampled on the serial clock as a framing qualifier, not crossed.
  always_comb begin
    link_nxt = link_r;
    if (!latchStrobe) begin
      link_nxt.shiftWord = {link_r.shiftWord[WORD_W-2:0], serialData};
    end
  end

  // The shift register clears with the bank reset, no serial clock needed.
  always_ff @(posedge serialClk or negedge rst_n) begin
    if (!rst_n) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // The strobe is the request of the crossing; the word is read only
  // after the strobe has passed two flops, when it has long settled.
  sync_stage #(
    .W(1),
    .RST_VAL(RST_STROBE)
  ) u_strobe_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .levelIn(latchStrobe),
    .levelOut(strobeSync)
  );

  // Read data selection for the current bus address.
  always_comb begin
    case (address)
      OFS_FRAC: rdMux = 32'(st_r.fracWord);
      OFS_LOOP: rdMux = 32'(st_r.loopWord);
      OFS_IFCTL: rdMux = 32'(st_r.ifCtlWord);
      OFS_RFDIV: rdMux = 32'(st_r.rfDivWord);
      OFS_CTRL: rdMux = 32'(st_r.latchAccept);
      OFS_STATUS: rdMux = {26'h0000000, st_r.fmodeOk, st_r.fracModeSet,
                           st_r.updated};
      default: rdMux = 32'h00000000;
    endcase
  end

  // Handshake, word loading and status upkeep.
  always_comb begin
    st_nxt = st_r;
    strobeRise = strobeSync & ~st_r.strobeSeen;
    st_nxt.strobeSeen = strobeSync;

    // Every request waits exactly one cycle; unmapped reads give zero.
    // The fixed wait lets read data come from a flop, not the mux.
    busReq = read | write;
    busDone = busReq & ~st_r.waitReq;
    doWrite = busDone & write;
    st_nxt.waitReq = 1'b1;
    if (busReq && st_r.waitReq) begin
      st_nxt.waitReq = 1'b0;
      st_nxt.rdata = rdMux;
    end

    // load on strobe rise
    // A serial load beats an injected word in the same cycle; the
    // injected one is dropped, and no status bit records the drop.
    loadValid = 1'b0;
    loadWord = '0;
    if (strobeRise && st_r.latchAccept) begin
      loadValid = 1'b1;
      loadWord = link_r.shiftWord;
    end else if (doWrite && address == OFS_INJECT) begin
      loadValid = 1'b1;
      loadWord = writedata[WORD_W-1:0];
    end

    updHit = 4'h0;
    if (loadValid) begin
      case (loadWord[1:0])
        ADDR_FRAC: begin
          st_nxt.fracWord = loadWord;
          updHit[0] = 1'b1;
        end
        ADDR_LOOP: begin
          st_nxt.loopWord = loadWord;
          updHit[1] = 1'b1;
        end
        ADDR_IFCTL: begin
          st_nxt.ifCtlWord = loadWord;
          updHit[2] = 1'b1;
        end
        default: begin
          st_nxt.rfDivWord = loadWord;
          updHit[3] = 1'b1;
        end
      endcase
    end

    // Update flags clear on a written one, but a load in the same
    // cycle wins so that no update goes unseen.
    if (doWrite && address == OFS_STATUS) begin
      st_nxt.updated = st_r.updated & ~writedata[3:0];
    end
    st_nxt.updated = st_nxt.updated | updHit;

    // Clearing the accept bit shuts out the serial port, for example
    // while software injects words of its own.
    if (doWrite && address == OFS_CTRL) begin
      st_nxt.latchAccept = writedata[CTRL_ACCEPT_BIT];
    end

    // mode programmed flag
    // Stays low until word 00b is loaded, serial or injected, after reset, so software
    // can tell that the fractional mode was never set up.
    if (updHit[0]) begin
      st_nxt.fracModeSet = 1'b1;
    end

    // pump current decode
    // The microamp copy saves monitoring logic a decode of its own.
    st_nxt.pump = st_r.loopWord[PUMP_MSB:PUMP_LSB];
    case (st_r.loopWord[PUMP_MSB:PUMP_LSB])
      2'h0: st_nxt.pumpUa = PUMP_UA_0;
      2'h1: st_nxt.pumpUa = PUMP_UA_1;
      2'h2: st_nxt.pumpUa = PUMP_UA_2;
      default: st_nxt.pumpUa = PUMP_UA_3;
    endcase

    // prescaler choice
    // The modulus output spares the user a decode of the select bit.
    st_nxt.presc = st_r.loopWord[PRESC_BIT];
    st_nxt.prescMod = st_r.loopWord[PRESC_BIT] ? PRESC_MOD_LARGE :
                      PRESC_MOD_SMALL;

    // reference ratio
    // The ratio passes unchanged; its meaning lies in the divider.
    st_nxt.refDiv = st_r.loopWord[REFDIV_MSB:REFDIV_LSB];

    // modulus extension
    // A zero extension leaves the plain modulus of the fraction field.
    st_nxt.modExt = st_r.loopWord[MODEXT_MSB:MODEXT_LSB];
    st_nxt.modExtOn = |st_r.loopWord[MODEXT_MSB:MODEXT_LSB];

    // IF polarity
    // One suits positive oscillator gain, zero negative gain.
    st_nxt.ifPol = st_r.ifCtlWord[IFPOL_BIT];

    // enable decode
    // Power-down clears both enables so that no loop runs half set up.
    enCode = st_r.ifCtlWord[EN_MSB:EN_LSB];
    case (enCode)
      EN_BOTH: begin
        st_nxt.rfEn = 1'b1;
        st_nxt.ifEn = 1'b1;
        st_nxt.pwrDown = 1'b0;
      end
      EN_RF_ONLY: begin
        st_nxt.rfEn = 1'b1;
        st_nxt.ifEn = 1'b0;
        st_nxt.pwrDown = 1'b0;
      end
      EN_IF_ONLY: begin
        st_nxt.rfEn = 1'b0;
        st_nxt.ifEn = 1'b1;
        st_nxt.pwrDown = 1'b0;
      end
      default: begin
        st_nxt.rfEn = 1'b0;
        st_nxt.ifEn = 1'b0;
        st_nxt.pwrDown = 1'b1;
      end
    endcase

    // IF main ratio
    // All 17 bits pass unchanged to the IF divider.
    st_nxt.ifDiv = st_r.ifCtlWord[IFDIV_MSB:IFDIV_LSB];

    // fraction numerator
    // Without an extension the modulus of this field is 256.
    st_nxt.fracNum = st_r.rfDivWord[FRAC_MSB:FRAC_LSB];

    // main ratio width
    // With the small prescaler the top bit is not used and reads zero.
    if (st_r.loopWord[PRESC_BIT]) begin
      st_nxt.rfDiv = st_r.rfDivWord[RFDIV_MSB:RFDIV_LSB];
    end else begin
      st_nxt.rfDiv = {1'b0,
        st_r.rfDivWord[RFDIV_LSB+RFDIV_NARROW_W-1:RFDIV_LSB]};
    end

    // fractional mode
    // Reserved codes leave the mode invalid and dithering off.
    fmode = st_r.fracWord[FMODE_MSB:FMODE_LSB];
    st_nxt.fmodeOk = (fmode == FMODE_DITHER) || (fmode == FMODE_PLAIN);
    st_nxt.dither = (fmode == FMODE_DITHER);
  end

  // All register-side state, reset to defined values.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.fracWord <= RST_FRAC_WORD;
      st_r.loopWord <= RST_LOOP_WORD;
      st_r.ifCtlWord <= RST_IFCTL_WORD;
      st_r.rfDivWord <= RST_RFDIV_WORD;
      st_r.strobeSeen <= RST_STROBE;
      st_r.latchAccept <= RST_ACCEPT;
      st_r.waitReq <= 1'b1;
      st_r.pumpUa <= PUMP_UA_0;
      st_r.prescMod <= PRESC_MOD_SMALL;
      st_r.pwrDown <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state flops.
  assign readdata = st_r.rdata;
  assign waitrequest = st_r.waitReq;
  assign rfPumpCurrent = st_r.pump;
  assign rfPumpCurrentUa = st_r.pumpUa;
  assign rfPrescalerSelect = st_r.presc;
  assign rfPrescalerModulus = st_r.prescMod;
  assign rfRefDivider = st_r.refDiv;
  assign rfModuloExtension = st_r.modExt;
  assign rfModulusExtended = st_r.modExtOn;
  assign ifPdPolarity = st_r.ifPol;
  assign rfEnable = st_r.rfEn;
  assign ifEnable = st_r.ifEn;
  assign powerDown = st_r.pwrDown;
  assign ifMainDivider = st_r.ifDiv;
  assign rfFractionWord = st_r.fracNum;
  assign rfMainDivider = st_r.rfDiv;
  assign fracModeValid = st_r.fmodeOk;
  assign ditherEnable = st_r.dither;

endmodule
